// ---- core/smbus_temp_pkg.sv ----
package smbus_temp_pkg;

   // Register pointer values.
   localparam logic [7:0] REG_CH1_TEMP  = 8'h00;
   localparam logic [7:0] REG_CH2_TEMP  = 8'h01;
   localparam logic [7:0] REG_GEN_CFG   = 8'h02;

   // Configuration register layout and reset value.
   localparam logic [7:0] GEN_CFG_RESET = 8'h00;
   localparam int         CH2_LOCAL_BIT = 1;

   // Value returned for a pointer that selects no register.
   localparam logic [7:0] UNMAPPED_READ = 8'h00;

   // Upper five address bits; the value is arbitrary.
   localparam logic [4:0] ADDR_HIGH     = 5'h04;

   // Bit counting within one byte on the bus.
   localparam logic [3:0] BYTE_BITS     = 4'h8;
   localparam logic [3:0] LAST_BIT      = 4'h7;
   localparam logic [3:0] CNT_ZERO      = 4'h0;
   localparam logic [3:0] CNT_ONE       = 4'h1;

   // Clipped temperature value and width of a raw reading.
   localparam logic [7:0] TEMP_FLOOR    = 8'h00;
   localparam int         MEAS_W        = 9;

   typedef struct packed {
      logic scl_rise;
      logic scl_fall;
      logic start;
      logic stop;
      logic sda;
   } line_ev_t;

   // Whole-degree readings in two's complement.
   typedef struct packed {
      logic signed [MEAS_W-1:0] remote1;
      logic signed [MEAS_W-1:0] remote2;
      logic signed [MEAS_W-1:0] die;
   } meas_t;

   typedef enum logic [3:0] {
      ST_IDLE      = 4'h0,
      ST_ADDR      = 4'h1,
      ST_ADDR_ACK  = 4'h3,
      ST_CMD       = 4'h2,
      ST_CMD_ACK   = 4'h6,
      ST_WDATA     = 4'h7,
      ST_WDATA_ACK = 4'h5,
      ST_RDATA     = 4'h4,
      ST_RDATA_ACK = 4'hc,
      ST_IGNORE    = 4'hd
   } state_t;

endpackage : smbus_temp_pkg

// ---- core/line_events.sv ----
module line_events (
   input  wire logic                     clk,   // System clock
   input  wire logic                     reset, // Synchronous, active high
   input  wire logic                     scl,   // Bus clock level
   input  wire logic                     sda,   // Bus data level
   output smbus_temp_pkg::line_ev_t      ev     // Decoded bus events
);

   logic scl_r;
   logic sda_r;
   logic scl_nxt;
   logic sda_nxt;

   always_comb begin
      scl_nxt     = scl;
      sda_nxt     = sda;
      ev.scl_rise = scl & ~scl_r;
      ev.scl_fall = ~scl & scl_r;
      // Data may only move while the clock is low, so an edge on data
      // with the clock held high marks a frame boundary.
      ev.start    = scl & scl_r & sda_r & ~sda;
      ev.stop     = scl & scl_r & ~sda_r & sda;
      ev.sda      = sda;
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         scl_r <= 1'b1;
         sda_r <= 1'b1;
      end else begin
         scl_r <= scl_nxt;
         sda_r <= sda_nxt;
      end
   end

endmodule : line_events

// ---- core/temp_clip.sv ----
module temp_clip (
   input  wire logic                                    clk,   // Clock
   input  wire logic                                    reset, // Sync reset
   input  wire logic signed [smbus_temp_pkg::MEAS_W-1:0] meas,  // Raw reading
   output logic             [7:0]                       temp   // Register
);

   logic [7:0] temp_nxt;

   always_comb begin
      temp_nxt = meas[7:0];
      if (meas[smbus_temp_pkg::MEAS_W-1]) begin
         temp_nxt = smbus_temp_pkg::TEMP_FLOOR;
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         temp <= smbus_temp_pkg::TEMP_FLOOR;
      end else begin
         temp <= temp_nxt;
      end
   end

   property p_clip_negative;
      @(posedge clk) disable iff (reset)
      (meas < 0) |=> (temp == smbus_temp_pkg::TEMP_FLOOR);
   endproperty
   a_clip_negative: assert property (p_clip_negative)
      else $error("Negative reading was not clipped to zero.");

   property p_whole_degrees;
      @(posedge clk) disable iff (reset)
      (meas >= 0) |=> (temp == $past(meas[7:0]));
   endproperty
   a_whole_degrees: assert property (p_whole_degrees)
      else $error("Positive reading not passed in whole degrees.");

endmodule : temp_clip

// ---- core/smbus_temp_register_port.sv ----
module smbus_temp_register_port (
   input  wire logic                  clk,       // 10 MHz system clock
   input  wire logic                  reset,     // Synchronous, active high
   input  wire logic [1:0]            addr_sel,  // Address variant strap
   input  wire logic                  scl,       // Bus clock from master
   input  wire logic                  sda_in,    // Bus data level
   input  wire smbus_temp_pkg::meas_t meas,      // Raw readings, degrees
   output logic                       sda_out,   // Data drive value
   output logic                       sda_oe,    // High pulls data low
   output logic                       ch2_local  // Channel 2 uses die
);

   smbus_temp_pkg::line_ev_t ev;
   smbus_temp_pkg::state_t   state_r;
   smbus_temp_pkg::state_t   state_nxt;

   logic [3:0] cnt_r;
   logic [3:0] cnt_nxt;
   logic [7:0] sh_r;
   logic [7:0] sh_nxt;
   logic [7:0] tx_r;
   logic [7:0] tx_nxt;
   logic       rw_r;
   logic       rw_nxt;
   logic [7:0] ptr_r;
   logic [7:0] ptr_nxt;
   logic [7:0] cfg_r;
   logic [7:0] cfg_nxt;
   logic       oe_r;
   logic       oe_nxt;
   logic [6:0] addr_r;
   logic [7:0] ch1_temp;
   logic [7:0] ch2_temp;
   logic [7:0] rd_data;
   logic signed [smbus_temp_pkg::MEAS_W-1:0] ch2_raw;

   line_events u_line_events (
      .clk   (clk),
      .reset (reset),
      .scl   (scl),
      .sda   (sda_in),
      .ev    (ev)
   );

   // Channel 2 source follows the configuration bit.
   assign ch2_raw = cfg_r[smbus_temp_pkg::CH2_LOCAL_BIT] ? meas.die
                                                         : meas.remote2;

   temp_clip u_clip_ch1 (
      .clk   (clk),
      .reset (reset),
      .meas  (meas.remote1),
      .temp  (ch1_temp)
   );

   temp_clip u_clip_ch2 (
      .clk   (clk),
      .reset (reset),
      .meas  (ch2_raw),
      .temp  (ch2_temp)
   );

   // Register file read side, one byte per pointer value.
   always_comb begin
      case (ptr_r)
         smbus_temp_pkg::REG_CH1_TEMP: rd_data = ch1_temp;
         smbus_temp_pkg::REG_CH2_TEMP: rd_data = ch2_temp;
         smbus_temp_pkg::REG_GEN_CFG:  rd_data = cfg_r;
         default:                      rd_data = smbus_temp_pkg::UNMAPPED_READ;
      endcase
   end

   always_comb begin
      state_nxt = state_r;
      cnt_nxt   = cnt_r;
      sh_nxt    = sh_r;
      tx_nxt    = tx_r;
      rw_nxt    = rw_r;
      ptr_nxt   = ptr_r;
      cfg_nxt   = cfg_r;
      oe_nxt    = oe_r;
      if (ev.stop) begin
         // A stop right after the command byte closes a send byte frame.
         state_nxt = smbus_temp_pkg::ST_IDLE;
         oe_nxt    = 1'b0;
      end else if (ev.start) begin
         // A repeated start lands here too, turning the frame to a read.
         state_nxt = smbus_temp_pkg::ST_ADDR;
         cnt_nxt   = smbus_temp_pkg::CNT_ZERO;
         oe_nxt    = 1'b0;
      end else begin
         case (state_r)
            smbus_temp_pkg::ST_ADDR,
            smbus_temp_pkg::ST_CMD,
            smbus_temp_pkg::ST_WDATA: begin
               if (ev.scl_rise) begin
                  sh_nxt  = {sh_r[6:0], ev.sda};
                  cnt_nxt = cnt_r + smbus_temp_pkg::CNT_ONE;
               end else if (ev.scl_fall &&
                            cnt_r == smbus_temp_pkg::BYTE_BITS) begin
                  cnt_nxt = smbus_temp_pkg::CNT_ZERO;
                  oe_nxt  = 1'b1;
                  if (state_r == smbus_temp_pkg::ST_ADDR) begin
                     if (sh_r[7:1] == addr_r) begin
                        rw_nxt    = sh_r[0];
                        state_nxt = smbus_temp_pkg::ST_ADDR_ACK;
                     end else begin
                        oe_nxt    = 1'b0;
                        state_nxt = smbus_temp_pkg::ST_IGNORE;
                     end
                  end else if (state_r == smbus_temp_pkg::ST_CMD) begin
                     ptr_nxt   = sh_r;
                     state_nxt = smbus_temp_pkg::ST_CMD_ACK;
                  end else begin
                     // Read-only and unmapped bytes take the ack only.
                     if (ptr_r == smbus_temp_pkg::REG_GEN_CFG) begin
                        cfg_nxt = sh_r;
                     end
                     state_nxt = smbus_temp_pkg::ST_WDATA_ACK;
                  end
               end
            end
            smbus_temp_pkg::ST_ADDR_ACK: begin
               if (ev.scl_fall) begin
                  if (rw_r) begin
                     tx_nxt    = rd_data;
                     oe_nxt    = ~rd_data[7];
                     state_nxt = smbus_temp_pkg::ST_RDATA;
                  end else begin
                     oe_nxt    = 1'b0;
                     state_nxt = smbus_temp_pkg::ST_CMD;
                  end
               end
            end
            smbus_temp_pkg::ST_CMD_ACK: begin
               if (ev.scl_fall) begin
                  oe_nxt    = 1'b0;
                  state_nxt = smbus_temp_pkg::ST_WDATA;
               end
            end
            smbus_temp_pkg::ST_WDATA_ACK: begin
               // Only one data byte per write frame; extra bytes get no ack.
               if (ev.scl_fall) begin
                  oe_nxt    = 1'b0;
                  state_nxt = smbus_temp_pkg::ST_IGNORE;
               end
            end
            smbus_temp_pkg::ST_RDATA: begin
               if (ev.scl_fall) begin
                  if (cnt_r == smbus_temp_pkg::LAST_BIT) begin
                     oe_nxt    = 1'b0;
                     cnt_nxt   = smbus_temp_pkg::CNT_ZERO;
                     state_nxt = smbus_temp_pkg::ST_RDATA_ACK;
                  end else begin
                     tx_nxt  = {tx_r[6:0], 1'b0};
                     oe_nxt  = ~tx_r[6];
                     cnt_nxt = cnt_r + smbus_temp_pkg::CNT_ONE;
                  end
               end
            end
            smbus_temp_pkg::ST_RDATA_ACK: begin
               if (ev.scl_rise && ev.sda) begin
                  state_nxt = smbus_temp_pkg::ST_IGNORE;
               end else if (ev.scl_fall) begin
                  // A master that acks gets the same register once more.
                  tx_nxt    = rd_data;
                  oe_nxt    = ~rd_data[7];
                  state_nxt = smbus_temp_pkg::ST_RDATA;
               end
            end
            default: begin
               state_nxt = state_r;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state_r <= smbus_temp_pkg::ST_IDLE;
         cnt_r   <= smbus_temp_pkg::CNT_ZERO;
         sh_r    <= smbus_temp_pkg::UNMAPPED_READ;
         tx_r    <= smbus_temp_pkg::UNMAPPED_READ;
         rw_r    <= 1'b0;
         ptr_r   <= smbus_temp_pkg::REG_CH1_TEMP;
         cfg_r   <= smbus_temp_pkg::GEN_CFG_RESET;
         oe_r    <= 1'b0;
         // The strap is caught while reset is held and kept afterwards.
         addr_r  <= {smbus_temp_pkg::ADDR_HIGH, addr_sel};
      end else begin
         state_r <= state_nxt;
         cnt_r   <= cnt_nxt;
         sh_r    <= sh_nxt;
         tx_r    <= tx_nxt;
         rw_r    <= rw_nxt;
         ptr_r   <= ptr_nxt;
         cfg_r   <= cfg_nxt;
         oe_r    <= oe_nxt;
      end
   end

   // Open drain: the driven level is always low, only the enable moves.
   always_ff @(posedge clk) begin
      if (reset) begin
         sda_out   <= 1'b0;
         sda_oe    <= 1'b0;
         ch2_local <= 1'b0;
      end else begin
         sda_out   <= 1'b0;
         sda_oe    <= oe_nxt;
         ch2_local <= cfg_nxt[smbus_temp_pkg::CH2_LOCAL_BIT];
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);

   property p_addr_match_acks;
      (state_r == smbus_temp_pkg::ST_ADDR && ev.scl_fall && !ev.stop &&
       !ev.start && cnt_r == smbus_temp_pkg::BYTE_BITS &&
       sh_r[7:1] == addr_r)
      |=> (sda_oe && state_r == smbus_temp_pkg::ST_ADDR_ACK);
   endproperty
   a_addr_match_acks: assert property (p_addr_match_acks)
      else $error("Own address was not acknowledged.");

   property p_addr_miss_silent;
      (state_r == smbus_temp_pkg::ST_ADDR && ev.scl_fall && !ev.stop &&
       !ev.start && cnt_r == smbus_temp_pkg::BYTE_BITS &&
       sh_r[7:1] != addr_r)
      |=> (!sda_oe && state_r == smbus_temp_pkg::ST_IGNORE);
   endproperty
   a_addr_miss_silent: assert property (p_addr_miss_silent)
      else $error("Foreign address was acknowledged.");

   property p_cmd_loads_ptr;
      (state_r == smbus_temp_pkg::ST_CMD && ev.scl_fall && !ev.stop &&
       !ev.start && cnt_r == smbus_temp_pkg::BYTE_BITS)
      |=> (ptr_r == $past(sh_r) && sda_oe);
   endproperty
   a_cmd_loads_ptr: assert property (p_cmd_loads_ptr)
      else $error("Command byte did not load the pointer.");

   property p_data_writes_cfg;
      (state_r == smbus_temp_pkg::ST_WDATA && ev.scl_fall && !ev.stop &&
       !ev.start && cnt_r == smbus_temp_pkg::BYTE_BITS &&
       ptr_r == smbus_temp_pkg::REG_GEN_CFG)
      |=> (cfg_r == $past(sh_r) && sda_oe);
   endproperty
   a_data_writes_cfg: assert property (p_data_writes_cfg)
      else $error("Data byte was not stored to configuration.");

   property p_readonly_kept;
      (ptr_r != smbus_temp_pkg::REG_GEN_CFG) |=> $stable(cfg_r);
   endproperty
   a_readonly_kept: assert property (p_readonly_kept)
      else $error("Configuration changed through another pointer.");

   // The clock rise that precedes a stop is counted as a data bit, so a
   // send byte frame reaches its stop with one bit in the counter.
   property p_send_byte_no_write;
      (ev.stop && state_r == smbus_temp_pkg::ST_WDATA &&
       cnt_r == smbus_temp_pkg::CNT_ONE)
      |=> ($stable(cfg_r) && state_r == smbus_temp_pkg::ST_IDLE);
   endproperty
   a_send_byte_no_write: assert property (p_send_byte_no_write)
      else $error("Send byte frame wrote a register.");

   property p_msb_first;
      (state_r == smbus_temp_pkg::ST_RDATA) |-> (oe_r == !tx_r[7]);
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("Driven data bit is not the top bit of the byte.");

   property p_read_ch1;
      (state_r == smbus_temp_pkg::ST_ADDR_ACK && ev.scl_fall && rw_r &&
       !ev.stop && !ev.start && ptr_r == smbus_temp_pkg::REG_CH1_TEMP)
      |=> (tx_r == $past(ch1_temp) &&
           state_r == smbus_temp_pkg::ST_RDATA);
   endproperty
   a_read_ch1: assert property (p_read_ch1)
      else $error("Read did not load the pointed register.");

   property p_nack_ends_read;
      (state_r == smbus_temp_pkg::ST_RDATA_ACK && ev.scl_rise && ev.sda &&
       !ev.stop && !ev.start)
      |=> (state_r == smbus_temp_pkg::ST_IGNORE) ##1 !sda_oe;
   endproperty
   a_nack_ends_read: assert property (p_nack_ends_read)
      else $error("Not-acknowledge did not end the read.");

   property p_ch2_die;
      (cfg_r[smbus_temp_pkg::CH2_LOCAL_BIT] && meas.die >= 0)
      |=> (ch2_temp == $past(meas.die[7:0]));
   endproperty
   a_ch2_die: assert property (p_ch2_die)
      else $error("Channel 2 does not follow the die sensor.");

endmodule : smbus_temp_register_port

// ---- dv/smbus_host_model.sv ----
module smbus_host_model (
   input  wire logic clk,      // System clock
   input  wire logic sda_wire, // Resolved data line
   output logic      scl,      // Bus clock to the device
   output logic      sda_m     // Master data, 1 releases the line
);
   timeunit 1ns;
   timeprecision 1ns;

   // Phase length in clock cycles; the bench stretches it for slow frames.
   int half = 8;

   initial begin
      scl   = 1'b1;
      sda_m = 1'b1;
   end

   task automatic wt(input int n);
      repeat (n) @(negedge clk);
   endtask : wt

   // Data is raised first so that a repeated start is formed correctly.
   task automatic start_cond();
      sda_m = 1'b1;
      wt(half / 2);
      scl = 1'b1;
      wt(half);
      sda_m = 1'b0;
      wt(half);
      scl = 1'b0;
      wt(half / 2);
   endtask : start_cond

   task automatic stop_cond();
      sda_m = 1'b0;
      wt(half / 2);
      scl = 1'b1;
      wt(half);
      sda_m = 1'b1;
      wt(half);
   endtask : stop_cond

   // Sampled at the end of the high phase, long after the device settles.
   task automatic bit_io(input logic b, output logic s);
      sda_m = b;
      wt(half / 2);
      scl = 1'b1;
      wt(half);
      s = sda_wire;
      scl = 1'b0;
      wt(half / 2);
   endtask : bit_io

   task automatic byte_wr(input logic [7:0] d, output logic ack);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(d[i], s);
      end
      bit_io(1'b1, s);
      ack = ~s;
   endtask : byte_wr

   // Reads end in not-acknowledge so the device lets go of the line.
   task automatic byte_rd(output logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--) begin
         bit_io(1'b1, s);
         d[i] = s;
      end
      bit_io(1'b1, s);
   endtask : byte_rd
endmodule : smbus_host_model

// ---- dv/tb_top.sv ----
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int LIMIT = 90000;
   logic                  clk;
   logic                  reset;
   logic [1:0]            addr_sel;
   logic                  scl;
   logic                  sda_m;
   logic                  sda_wire;
   logic                  sda_out;
   logic                  sda_oe;
   logic                  ch2_local;
   logic [6:0]            dev_addr;
   logic [8:0]            edge_v [3] = '{9'h1ff, 9'h000, 9'h0ff};
   smbus_temp_pkg::meas_t meas;
   int                    bad_count = 0;
   int                    n_tests   = 0;
   int                    cycles    = 0;
   int                    ref_cfg;
   int                    ref_ptr;

   // Pull-up on the data line: low while either side pulls it.
   // The device's drive value counts too, so a wrong level would show.
   assign sda_wire = sda_m & (~sda_oe | sda_out);
   assign dev_addr = {smbus_temp_pkg::ADDR_HIGH, addr_sel};

   smbus_temp_register_port i_dut (.clk(clk), .reset(reset),
      .addr_sel(addr_sel), .scl(scl), .sda_in(sda_wire), .meas(meas),
      .sda_out(sda_out), .sda_oe(sda_oe), .ch2_local(ch2_local));
   smbus_host_model i_host (.clk(clk), .sda_wire(sda_wire), .scl(scl),
      .sda_m(sda_m));

   initial begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   task automatic conclude();
      $display("Comparisons %0d, mismatches %0d", n_tests, bad_count);
      if (bad_count == 0 && n_tests > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask : conclude

   always @(posedge clk) begin
      cycles++;
      if (cycles == LIMIT) begin
         bad_count++;
         conclude();
      end
   end

   task automatic check(input string what, input logic [7:0] seen,
                        input logic [7:0] exp);
      n_tests++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   function automatic logic [7:0] clip(input logic signed [8:0] v);
      return (v < 0) ? 8'h00 : v[7:0];
   endfunction : clip

   function automatic logic [7:0] ref_reg(input int p);
      case (p)
         0: return clip(meas.remote1);
         1: return clip(ref_cfg[1] ? meas.die : meas.remote2);
         2: return ref_cfg[7:0];
         default: return smbus_temp_pkg::UNMAPPED_READ;
      endcase
   endfunction : ref_reg

   task automatic do_reset(input logic [1:0] sel);
      @(negedge clk);
      reset    = 1'b1;
      addr_sel = sel;
      repeat (3) @(negedge clk);
      check("oe in reset", {7'h00, sda_oe}, 8'h00);
      check("ch2 in reset", {7'h00, ch2_local}, 8'h00);
      reset   = 1'b0;
      ref_cfg = smbus_temp_pkg::GEN_CFG_RESET;
      ref_ptr = 0;
   endtask : do_reset

   task automatic rand_meas();
      meas.remote1 = 9'($urandom);
      meas.remote2 = 9'($urandom);
      meas.die     = 9'($urandom);
   endtask : rand_meas

   task automatic addr_ph(input logic rd);
      logic a;
      i_host.start_cond();
      i_host.byte_wr({dev_addr, rd}, a);
      check("addr ack", {7'h00, a}, 8'h01);
   endtask : addr_ph

   task automatic cmd_ph(input logic [7:0] c);
      logic a;
      addr_ph(1'b0);
      i_host.byte_wr(c, a);
      check("cmd ack", {7'h00, a}, 8'h01);
      ref_ptr = c;
   endtask : cmd_ph

   task automatic wr_byte(input logic [7:0] c, input logic [7:0] d);
      logic a;
      cmd_ph(c);
      i_host.byte_wr(d, a);
      check("data ack", {7'h00, a}, 8'h01);
      i_host.stop_cond();
      if (c == smbus_temp_pkg::REG_GEN_CFG) begin
         ref_cfg = d;
      end
   endtask : wr_byte

   task automatic send_byte(input logic [7:0] c);
      cmd_ph(c);
      i_host.stop_cond();
   endtask : send_byte

   task automatic rd_chk(input logic [7:0] c);
      logic [7:0] d;
      cmd_ph(c);
      addr_ph(1'b1);
      i_host.byte_rd(d);
      i_host.stop_cond();
      check("read data", d, ref_reg(c));
   endtask : rd_chk

   // With a single master nobody else can move the pointer.
   task automatic rcv_chk();
      logic [7:0] d;
      addr_ph(1'b1);
      i_host.byte_rd(d);
      i_host.stop_cond();
      check("rcv data", d, ref_reg(ref_ptr));
   endtask : rcv_chk

   initial begin
      logic [7:0] d;
      logic       a;
      reset    = 1'b1;
      addr_sel = 2'h0;
      meas     = '0;
      d        = 8'($urandom(59));
      for (int s = 0; s < 4; s++) begin
         do_reset(s[1:0]);
         rand_meas();
         rcv_chk();
         i_host.start_cond();
         i_host.byte_wr({smbus_temp_pkg::ADDR_HIGH, s[1:0] + 2'h1, 1'b0}, a);
         check("foreign ack", {7'h00, a}, 8'h00);
         i_host.stop_cond();
      end
      $display("addresses done");
      for (int i = 0; i < 10; i++) begin
         i_host.half = (i % 2 == 1) ? 20 : 6;
         rand_meas();
         if (i < 3) begin
            meas = {3{edge_v[i]}};
         end
         d = 8'($urandom);
         wr_byte(smbus_temp_pkg::REG_GEN_CFG, {d[7:2], i[0], d[0]});
         check("ch2 src", {7'h00, ch2_local}, {7'h00, ref_cfg[1]});
         for (int p = 0; p < 3; p++) begin
            rd_chk(p[7:0]);
         end
      end
      $display("reads done");
      // Read-only and unmapped places take the write but keep nothing.
      wr_byte(smbus_temp_pkg::REG_CH1_TEMP, 8'h5a);
      rd_chk(smbus_temp_pkg::REG_CH1_TEMP);
      wr_byte(8'h37, 8'ha5);
      rd_chk(8'h37);
      rd_chk(smbus_temp_pkg::REG_GEN_CFG);
      $display("protected writes done");
      send_byte(smbus_temp_pkg::REG_CH2_TEMP);
      rcv_chk();
      send_byte(smbus_temp_pkg::REG_GEN_CFG);
      rcv_chk();
      rd_chk(smbus_temp_pkg::REG_CH1_TEMP);
      rcv_chk();
      $display("short frames done");
      // Only one data byte belongs to a write frame.
      cmd_ph(smbus_temp_pkg::REG_GEN_CFG);
      i_host.byte_wr(8'h0f, a);
      i_host.byte_wr(8'hf0, a);
      check("extra ack", {7'h00, a}, 8'h00);
      i_host.stop_cond();
      ref_cfg = 8'h0f;
      rcv_chk();
      check("ch2 src", {7'h00, ch2_local}, 8'h01);
      $display("extra byte done");
      conclude();
   end
endmodule : tb_top
